// ---- testbench/tpw_pin_model.sv ----
// pin partner: resolves each channel wire from unit drive, stimulus and pull-up
// assumes the bench changes stimulus just after rising edges
`timescale 1ns/1ps
module tpw_pin_model (
	input wire core_clk,
	input wire [1:0] chPinOut,
	input wire [1:0] chPinOeB,
	input wire [1:0] pullUpEn,
	input wire [1:0] drv,
	input wire [1:0] drvEn,
	output reg [1:0] chPinIn
);
// ============================================================
// wire level
reg [1:0] floatReg = 2'h0;
integer k;
// an undriven line keeps moving so no settled value passes for a level
always @(posedge core_clk) floatReg <= ~floatReg;
always @* begin
	for (k = 0; k < 2; k = k + 1) begin
		if (!chPinOeB[k]) chPinIn[k] = chPinOut[k];
		else if (drvEn[k]) chPinIn[k] = drv[k];
		else if (pullUpEn[k]) chPinIn[k] = 1'h1;
		else chPinIn[k] = floatReg[k];
	end
end
endmodule // tpw_pin_model

// ---- testbench/tpw_timer_assertions.sv ----
// checker for the bus answer and the reset state of the timer
// assumes synchronous active-low reset and one wait state per access
`timescale 1ns/1ps
module tpw_timer_checker (
	input wire core_clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [1:0] chPinOeB,
	input wire [1:0] pullUpEn,
	input wire irqOverflow,
	input wire [1:0] irqChannel
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
// ============================================================
// bus answer
ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable)) else $error("stray pready");
err_high_a: assert property (pready && paddr > 8'h1C |-> pslverr) else $error("unmapped accepted");
err_low_a: assert property (pready && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
	else $error("mapped refused");
err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
// held data lets software sample late without a race
rdata_hold_a: assert property (!pready |-> $stable(prdata)) else $error("prdata moved");
// ============================================================
// reset state
reset_state_a: assert property (disable iff (1'h0) !rst_b |=> chPinOeB == 2'h3 && pullUpEn == 2'h0
	&& !irqOverflow && irqChannel == 2'h0 && !pready) else $error("bad reset state");
endmodule // tpw_timer_checker
bind tpw_timer tpw_timer_checker i_chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.chPinOeB(chPinOeB), .pullUpEn(pullUpEn), .irqOverflow(irqOverflow), .irqChannel(irqChannel));

// ---- testbench/tpw_timer_test.sv ----
// self-checking bench of the timer: apb master, pin partner, scenario tasks
// assumes one wait state per access and synchronous pin inputs
`timescale 1ns/1ps
module tpw_timer_test;
// ============================================================
// clock, reset and unit
reg core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, auxClkPin = 0, slowOscClk = 0, perr;
reg [7:0] paddr = 0;
reg [31:0] pwdata = 0, rv;
reg [1:0] gpioData = 0, gpioDirOut = 0, drv = 0, drvEn = 0;
wire [31:0] prdata;
wire pready, pslverr, irqOverflow;
wire [1:0] chPinIn, chPinOut, chPinOeB, pullUpEn, irqChannel;
integer n_fail = 0, samples_checked = 0, cyc = 0, b;
initial forever #50 core_clk = ~core_clk;
always @(posedge core_clk) cyc <= cyc + 1;
tpw_timer i_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.auxClkPin(auxClkPin), .slowOscClk(slowOscClk), .chPinIn(chPinIn), .chPinOut(chPinOut),
	.chPinOeB(chPinOeB), .gpioData(gpioData), .gpioDirOut(gpioDirOut), .pullUpEn(pullUpEn),
	.irqOverflow(irqOverflow), .irqChannel(irqChannel));
tpw_pin_model i_pin (.core_clk(core_clk), .chPinOut(chPinOut), .chPinOeB(chPinOeB),
	.pullUpEn(pullUpEn), .drv(drv), .drvEn(drvEn), .chPinIn(chPinIn));
// ============================================================
// shared tasks
task end_of_test;
	if (n_fail == 0 && samples_checked > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task chk(input string nm, input [31:0] e, input [31:0] g);
	samples_checked = samples_checked + 1;
	if (e !== g) begin
		n_fail = n_fail + 1;
		$display("wrong value %s expected %h seen %h", nm, e, g);
	end
endtask
task bus(input w, input [7:0] ad, input [31:0] d);
	integer k;
	@(posedge core_clk);
	psel <= 1;
	pwrite <= w;
	paddr <= ad;
	pwdata <= d;
	@(posedge core_clk);
	penable <= 1;
	k = 0;
	do begin
		@(posedge core_clk);
		k = k + 1;
	end while (pready !== 1'h1 && k < 20);
	rv = prdata;
	perr = pslverr;
	psel <= 0;
	penable <= 0;
	if (pready !== 1'h1) begin
		n_fail = n_fail + 1;
		end_of_test;
	end
endtask
task waitc(input integer n);
	repeat (n) @(posedge core_clk);
endtask
// ============================================================
// scenarios
task t_reset;
	bus(0, 8'h00, 0);
	chk("sc", 0, rv);
	bus(0, 8'h04, 0);
	chk("cnt", 0, rv);
	bus(0, 8'h20, 0);
	chk("err", 1, perr);
	chk("bad", 0, rv);
endtask
task t_presc;
	integer p, c0, v0, g;
	for (p = 0; p < 8; p = p + 1) begin
		bus(1, 8'h00, 32'h08 | p);
		bus(1, 8'h04, 32'hFFFF);
		bus(0, 8'h04, 0);
		v0 = rv;
		c0 = cyc;
		chk("cntrst", 1, v0 < 8);
		waitc(300);
		bus(0, 8'h04, 0);
		g = cyc - c0;
		chk("tick", 1, rv - v0 >= g >> p && rv - v0 <= (g + (1 << p) - 1) >> p);
	end
endtask
task t_clk;
	integer s;
	for (s = 0; s < 4; s = s + 1) begin
		bus(1, 8'h00, s << 3);
		bus(1, 8'h04, 0);
		repeat (10) begin
			waitc(4);
			auxClkPin <= ~auxClkPin;
		end
		waitc(6);
		bus(0, 8'h04, 0);
		if (s == 0) chk("off", 0, rv);
		else if (s == 3) chk("aux", 5, rv);
		else chk("system_bus_clock", 1, rv > 40);
	end
endtask
task t_ovf;
	bus(1, 8'h08, 32'hFF);
	bus(1, 8'h00, 32'h48);
	bus(1, 8'h04, 0);
	waitc(260);
	chk("irq", 1, irqOverflow);
	bus(0, 8'h00, 0);
	chk("flag", 32'hC8, rv);
	bus(1, 8'h00, 32'h48);
	bus(0, 8'h00, 0);
	chk("clear", 32'h48, rv);
	chk("irq0", 0, irqOverflow);
	bus(0, 8'h04, 0);
	chk("mod", 1, rv <= 32'hFF);
	waitc(260);
	bus(1, 8'h00, 32'h48);
	bus(0, 8'h00, 0);
	chk("noclr", 32'hC8, rv);
	bus(1, 8'h00, 32'h08);
	waitc(2);
	chk("noirq", 0, irqOverflow);
endtask
task t_cmp;
	integer m;
	bus(1, 8'h08, 32'h3F);
	bus(1, 8'h10, 32'h20);
	for (m = 3; m > 0; m = m - 1) begin
		bus(1, 8'h0C, 32'h10 | m << 2);
		waitc(70);
		b = chPinOut[0];
		waitc(64);
		chk("oe", 0, chPinOeB[0]);
		chk("cmp", m == 3 ? 1 : m == 2 ? 0 : !b, chPinOut[0]);
	end
	bus(1, 8'h0C, 0);
	gpioDirOut <= 2'h1;
	gpioData <= 2'h2;
	waitc(3);
	chk("gpio", 4'hA, {chPinOeB, chPinOut});
endtask
task t_cap;
	integer e;
	drvEn <= 2'h2;
	for (e = 1; e < 4; e = e + 1) begin
		bus(1, 8'h14, 32'h40 | e << 2);
		bus(0, 8'h14, 0);
		bus(1, 8'h14, 32'h40 | e << 2);
		drv <= 2'h2;
		waitc(4);
		chk("rise", e & 1, irqChannel[1]);
		bus(0, 8'h14, 0);
		bus(1, 8'h14, 32'h40 | e << 2);
		drv <= 2'h0;
		waitc(4);
		chk("fall", e >> 1, irqChannel[1]);
	end
	drvEn <= 2'h3;
	bus(1, 8'h1C, 32'h3);
	bus(1, 8'h0C, 32'h44);
	bus(0, 8'h0C, 0);
	bus(1, 8'h0C, 32'h44);
	slowOscClk <= 1;
	waitc(4);
	chk("slow", 1, irqChannel[0]);
	chk("pull", 1, pullUpEn);
endtask
task t_pwm;
	integer n, s;
	bus(1, 8'h08, 32'h3F);
	bus(1, 8'h18, 32'h10);
	for (s = 0; s < 3; s = s + 1) begin
		bus(1, 8'h00, s == 2 ? 32'h28 : 32'h08);
		bus(1, 8'h14, s == 1 ? 32'h2C : 32'h28);
		waitc(140);
		n = 0;
		repeat (s == 2 ? 126 : 64) begin
			@(posedge core_clk);
			n = n + chPinOut[1];
		end
		chk("pwm", s == 0 ? 16 : s == 1 ? 48 : 31, n);
	end
	bus(1, 8'h00, 32'h08);
endtask
// ============================================================
// main sequence
initial begin
	waitc(5);
	rst_b <= 1;
	t_reset;
	t_presc;
	t_clk;
	t_ovf;
	t_cmp;
	t_cap;
	t_pwm;
	end_of_test;
end
endmodule // tpw_timer_test

// ---- verilog/tpw_channel.v ----
// one timer channel: capture, output compare, buffered PWM and its flag
// assumes the shared counter and its step pulses come from the timer top
`timescale 1ns/1ps
`include "tpw_timer_regs.vh"
module tpw_channel (
	input wire core_clk,
	input wire rst_b,
	input wire countStep,
	input wire reload,
	input wire [15:0] cnt,
	input wire centerMode,
	input wire [3:0] cfg,
	input wire [15:0] chVal,
	input wire capIn,
	input wire flagRead,
	input wire flagWriteZero,
	output reg flag,
	output wire capEvt,
	output wire pinOwned,
	output wire pinDrive,
	output reg pinLevel
);
	wire [1:0] modeSel = cfg[3:2];
	wire [1:0] edgeSel = cfg[1:0];
	wire isCap = !centerMode && modeSel == `TPW_MS_CAPTURE;
	wire isCmp = !centerMode && modeSel == `TPW_MS_COMPARE;
	wire isPwm = centerMode || modeSel[1];
	reg capPrev_reg;
	reg armed_reg;
	reg [15:0] valBuf_reg;
	wire rise = capIn && !capPrev_reg;
	wire fall = !capIn && capPrev_reg;
	wire matchEvt;
	wire flagSet;
	// ============================================================
	// pin ownership
	assign pinOwned = edgeSel != `TPW_ELS_NONE;
	assign pinDrive = !isCap;
	// ============================================================
	// events
	assign capEvt = isCap && ((edgeSel[0] && rise) || (edgeSel[1] && fall));
	assign matchEvt = countStep && (isCmp || isPwm) && cnt == (isPwm ? valBuf_reg : chVal);
	assign flagSet = capEvt || matchEvt;
	always @(posedge core_clk) begin
		if (!rst_b) begin
			capPrev_reg <= 1'b0;
			valBuf_reg <= `TPW_RST_WORD;
			pinLevel <= 1'b0;
			flag <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			capPrev_reg <= capIn;
			// duty changes only at the period boundary, so no runt pulses
			if (reload || !isPwm)
				valBuf_reg <= chVal;
			if (isPwm)
				pinLevel <= (cnt < valBuf_reg) ? !edgeSel[0] : edgeSel[0];
			else if (isCmp && matchEvt) begin
				case (edgeSel)
					`TPW_ELS_TOGGLE: pinLevel <= !pinLevel;
					`TPW_ELS_CLEAR: pinLevel <= 1'b0;
					`TPW_ELS_SET: pinLevel <= 1'b1;
					default: pinLevel <= pinLevel;
				endcase
			end
			// a new event wins over the clear and restarts the sequence
			flag <= flagSet || (flag && !(flagWriteZero && armed_reg));
			if (flagSet)
				armed_reg <= 1'b0;
			else if (flagRead && flag)
				armed_reg <= 1'b1;
			else if (flagWriteZero)
				armed_reg <= 1'b0;
		end
	end
endmodule // tpw_channel

// ---- verilog/tpw_timer.v ----
// two-channel 16-bit timer/PWM unit with an APB register slave
// assumes synchronous pin inputs, a port block supplying fallback pin data and direction
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tpw_timer_regs.vh"
module tpw_timer (
	input wire core_clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire auxClkPin,
	input wire slowOscClk,
	input wire [1:0] chPinIn,
	output reg [1:0] chPinOut,
	output reg [1:0] chPinOeB,
	input wire [1:0] gpioData,
	input wire [1:0] gpioDirOut,
	output reg [1:0] pullUpEn,
	output reg irqOverflow,
	output reg [1:0] irqChannel
);
	// ============================================================
	// state
	reg ovfFlag_reg;
	reg ovfArmed_reg;
	reg ovfIe_reg;
	reg center_reg;
	reg [1:0] clkSel_reg;
	reg [2:0] preSel_reg;
	reg [15:0] cnt_reg;
	reg [15:0] mod_reg;
	reg countUp_reg;
	reg [6:0] pre_reg;
	reg auxSync1_reg;
	reg auxSync2_reg;
	reg auxSync3_reg;
	reg countStep_reg;
	reg reload_reg;
	reg slowRoute_reg;
	reg [1:0] pullCfg_reg;
	reg [4:0] chCfg_reg [0:1];
	reg [15:0] chVal_reg [0:1];
	reg [15:0] cnt_next;
	reg countUp_next;
	reg ovfSet;
	reg [31:0] readData;
	reg addrHit;
	reg srcTick;
	reg [15:0] cntTop;
	integer i;
	integer j;
	wire [1:0] chFlag;
	wire [1:0] chCap;
	wire [1:0] chOwned;
	wire [1:0] chDrive;
	wire [1:0] chLevel;
	wire [1:0] capSrc;
	// ============================================================
	// bus strobes: one wait state, access completes when pready is seen high
	wire access = psel && penable && pready;
	wire wrEn = access && pwrite;
	wire rdEn = access && !pwrite;
	wire wrSc = wrEn && paddr == `TPW_OFF_SC;
	wire rdSc = rdEn && paddr == `TPW_OFF_SC;
	wire wrCnt = wrEn && paddr == `TPW_OFF_CNT;
	wire [1:0] chScHit;
	wire [1:0] chValHit;
	assign chScHit[0] = paddr == `TPW_OFF_CH0_SC;
	assign chScHit[1] = paddr == `TPW_OFF_CH0_SC + `TPW_CH_STRIDE;
	assign chValHit[0] = paddr == `TPW_OFF_CH0_VAL;
	assign chValHit[1] = paddr == `TPW_OFF_CH0_VAL + `TPW_CH_STRIDE;
	// ============================================================
	// clock source and prescaler
	// the aux pin is sampled twice before the edge detector looks at it
	wire auxRise = auxSync2_reg && !auxSync3_reg;
	always @* begin
		case (clkSel_reg)
			`TPW_CLKS_OFF: srcTick = 1'b0;
			`TPW_CLKS_AUX: srcTick = auxRise;
			default: srcTick = 1'b1;
		endcase
	end
	// ============================================================
	// prescaler output
	// a new divisor takes effect in the cycle after the write; pre_reg keeps its count
	wire [6:0] preMask = 7'h7F >> (3'h7 - preSel_reg);
	wire tick = srcTick && ((pre_reg & preMask) == preMask);
	always @* begin
		// a zero modulus would otherwise freeze the count; all-ones already wraps at FFFF, as the full range does
		if (mod_reg == `TPW_CNT_ZERO || mod_reg == `TPW_CNT_FULL)
			cntTop = `TPW_CNT_FULL;
		else
			cntTop = mod_reg;
	end
	// ============================================================
	// counter next state
	always @* begin
		cnt_next = cnt_reg;
		countUp_next = countUp_reg;
		ovfSet = 1'b0;
		if (!center_reg)
			countUp_next = 1'b1;
		if (tick) begin
			if (!center_reg) begin
				if (cnt_reg >= cntTop) begin
					cnt_next = `TPW_CNT_ZERO;
					ovfSet = 1'b1;
				end else
					cnt_next = cnt_reg + 16'h0001;
			end else if (countUp_reg) begin
				if (cnt_reg >= cntTop) begin
					cnt_next = cnt_reg - 16'h0001;
					countUp_next = 1'b0;
					ovfSet = 1'b1;
				end else
					cnt_next = cnt_reg + 16'h0001;
			end else begin
				if (cnt_reg == `TPW_CNT_ZERO) begin
					cnt_next = cnt_reg + 16'h0001;
					countUp_next = 1'b1;
				end else
					cnt_next = cnt_reg - 16'h0001;
			end
		end
	end
	// ============================================================
	// counter, prescaler, aux synchronizer and step/reload pulses
	always @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_reg <= `TPW_RST_WORD;
			countUp_reg <= 1'b1;
			pre_reg <= 7'h00;
			auxSync1_reg <= 1'b0;
			auxSync2_reg <= 1'b0;
			auxSync3_reg <= 1'b0;
			countStep_reg <= 1'b0;
			reload_reg <= 1'b0;
		end else begin
			auxSync1_reg <= auxClkPin;
			auxSync2_reg <= auxSync1_reg;
			auxSync3_reg <= auxSync2_reg;
			if (wrCnt) begin
				// prescaler restarts too, so the first period after the write is whole
				cnt_reg <= `TPW_CNT_ZERO;
				countUp_reg <= 1'b1;
				pre_reg <= 7'h00;
			end else begin
				cnt_reg <= cnt_next;
				countUp_reg <= countUp_next;
				if (srcTick)
					pre_reg <= pre_reg + 7'h01;
			end
			countStep_reg <= tick && !wrCnt;
			reload_reg <= ovfSet && !wrCnt;
		end
	end
	// ============================================================
	// overflow flag
	// writing one leaves the flag alone; only a zero after a read clears it
	wire ovfClear = wrSc && !pwdata[`TPW_SC_OVF] && ovfArmed_reg;
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ovfFlag_reg <= 1'b0;
			ovfArmed_reg <= 1'b0;
		end else begin
			// set wins over the clear; a new overflow restarts the clearing sequence
			ovfFlag_reg <= ovfSet || (ovfFlag_reg && !ovfClear);
			if (ovfSet)
				ovfArmed_reg <= 1'b0;
			else if (rdSc && ovfFlag_reg)
				ovfArmed_reg <= 1'b1;
			else if (wrSc)
				ovfArmed_reg <= 1'b0;
		end
	end
	// ============================================================
	// software registers
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ovfIe_reg <= 1'b0;
			center_reg <= 1'b0;
			clkSel_reg <= `TPW_CLKS_OFF;
			preSel_reg <= 3'h0;
			mod_reg <= `TPW_RST_WORD;
			slowRoute_reg <= 1'b0;
			pullCfg_reg <= 2'h0;
			for (i = 0; i < 2; i = i + 1) begin
				chCfg_reg[i] <= 5'h00;
				chVal_reg[i] <= `TPW_RST_WORD;
			end
		end else begin
			if (wrSc) begin
				ovfIe_reg <= pwdata[`TPW_SC_OVF_IE];
				center_reg <= pwdata[`TPW_SC_CENTER];
				clkSel_reg <= pwdata[`TPW_SC_CLKS_HI:`TPW_SC_CLKS_LO];
				preSel_reg <= pwdata[`TPW_SC_PS_HI:`TPW_SC_PS_LO];
			end
			if (wrEn && paddr == `TPW_OFF_MOD)
				mod_reg <= pwdata[15:0];
			if (wrEn && paddr == `TPW_OFF_OPT) begin
				slowRoute_reg <= pwdata[`TPW_OPT_SLOW_ROUTE];
				pullCfg_reg <= pwdata[`TPW_OPT_PULL_LO + 1:`TPW_OPT_PULL_LO];
			end
			for (i = 0; i < 2; i = i + 1) begin
				if (wrEn && chScHit[i])
					chCfg_reg[i] <= pwdata[`TPW_CH_IE:`TPW_CH_CFG_LO];
				// a capture takes precedence over a software write in the same cycle
				if (chCap[i])
					chVal_reg[i] <= cnt_reg;
				else if (wrEn && chValHit[i])
					chVal_reg[i] <= pwdata[15:0];
			end
		end
	end
	// ============================================================
	// channels
	assign capSrc[0] = slowRoute_reg ? slowOscClk : chPinIn[0];
	assign capSrc[1] = chPinIn[1];
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			tpw_channel uChan (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.countStep(countStep_reg),
				.reload(reload_reg),
				.cnt(cnt_reg),
				.centerMode(center_reg),
				.cfg(chCfg_reg[g][3:0]),
				.chVal(chVal_reg[g]),
				.capIn(capSrc[g]),
				.flagRead(rdEn && chScHit[g] && chFlag[g]),
				.flagWriteZero(wrEn && chScHit[g] && !pwdata[`TPW_CH_FLAG]),
				.flag(chFlag[g]),
				.capEvt(chCap[g]),
				.pinOwned(chOwned[g]),
				.pinDrive(chDrive[g]),
				.pinLevel(chLevel[g])
			);
		end
	endgenerate
	// ============================================================
	// read mux
	always @* begin
		readData = 32'h00000000;
		addrHit = 1'b1;
		case (paddr)
			`TPW_OFF_SC: readData[7:0] = {ovfFlag_reg, ovfIe_reg, center_reg, clkSel_reg, preSel_reg};
			`TPW_OFF_CNT: readData[15:0] = cnt_reg;
			`TPW_OFF_MOD: readData[15:0] = mod_reg;
			`TPW_OFF_CH0_SC: readData[7:0] = {chFlag[0], chCfg_reg[0], 2'h0};
			`TPW_OFF_CH0_VAL: readData[15:0] = chVal_reg[0];
			`TPW_OFF_CH0_SC + `TPW_CH_STRIDE: readData[7:0] = {chFlag[1], chCfg_reg[1], 2'h0};
			`TPW_OFF_CH0_VAL + `TPW_CH_STRIDE: readData[15:0] = chVal_reg[1];
			`TPW_OFF_OPT: readData[2:0] = {pullCfg_reg, slowRoute_reg};
			default: addrHit = 1'b0;
		endcase
	end
	// ============================================================
	// bus answer, all from flops
	// one wait state keeps the read mux off the bus timing path
	always @(posedge core_clk) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addrHit;
			if (psel && penable && !pready && !pwrite)
				prdata <= readData;
		end
	end
	// ============================================================
	// interrupt requests
	// levels, so a request stays up until software clears its flag or its interrupt enable
	always @(posedge core_clk) begin
		if (!rst_b) begin
			irqOverflow <= 1'b0;
			irqChannel <= 2'h0;
		end else begin
			irqOverflow <= ovfFlag_reg && ovfIe_reg;
			irqChannel[0] <= chFlag[0] && chCfg_reg[0][4];
			irqChannel[1] <= chFlag[1] && chCfg_reg[1][4];
		end
	end
	// ============================================================
	// pin control
	// port logic keeps the pin whenever the channel has no pin function
	always @(posedge core_clk) begin
		if (!rst_b) begin
			chPinOut <= 2'h0;
			chPinOeB <= 2'h3;
			pullUpEn <= 2'h0;
		end else begin
			for (j = 0; j < 2; j = j + 1) begin
				if (chOwned[j]) begin
					chPinOut[j] <= chLevel[j];
					chPinOeB[j] <= !chDrive[j];
					pullUpEn[j] <= pullCfg_reg[j] && !chDrive[j];
				end else begin
					chPinOut[j] <= gpioData[j];
					chPinOeB[j] <= !gpioDirOut[j];
					pullUpEn[j] <= 1'b0;
				end
			end
		end
	end
endmodule // tpw_timer

// ---- verilog/tpw_timer_regs.vh ----
// register map, field positions, reset values and codes of the two-channel timer/PWM unit
// assumes a 32-bit APB slave with one register per aligned word
`ifndef TPW_TIMER_REGS_VH
`define TPW_TIMER_REGS_VH
// ============================================================
// register byte offsets
`define TPW_OFF_SC 8'h00
`define TPW_OFF_CNT 8'h04
`define TPW_OFF_MOD 8'h08
`define TPW_OFF_CH0_SC 8'h0C
`define TPW_OFF_CH0_VAL 8'h10
`define TPW_OFF_OPT 8'h1C
`define TPW_CH_STRIDE 8'h08
// ============================================================
// status/control fields
`define TPW_SC_OVF 7
`define TPW_SC_OVF_IE 6
`define TPW_SC_CENTER 5
`define TPW_SC_CLKS_HI 4
`define TPW_SC_CLKS_LO 3
`define TPW_SC_PS_HI 2
`define TPW_SC_PS_LO 0
// channel status/control fields
`define TPW_CH_FLAG 7
`define TPW_CH_IE 6
`define TPW_CH_CFG_HI 5
`define TPW_CH_CFG_LO 2
// option register fields
`define TPW_OPT_SLOW_ROUTE 0
`define TPW_OPT_PULL_LO 1
// ============================================================
// codes and reset values
`define TPW_CLKS_OFF 2'h0
`define TPW_CLKS_AUX 2'h3
`define TPW_MS_CAPTURE 2'h0
`define TPW_MS_COMPARE 2'h1
`define TPW_ELS_NONE 2'h0
`define TPW_ELS_TOGGLE 2'h1
`define TPW_ELS_CLEAR 2'h2
`define TPW_ELS_SET 2'h3
`define TPW_CNT_FULL 16'hFFFF
`define TPW_CNT_ZERO 16'h0000
`define TPW_RST_BYTE 8'h00
`define TPW_RST_WORD 16'h0000
`endif
